// file: logic/cdtp_pkg.sv
// Purpose: Shared constants for the coprocessor data-transfer port
// Assumes: Single 100 MHz clock, synchronous active-high reset
// Notes:   Order tag codes count outstanding operations by age
package cdtp_pkg;
	localparam int          CDTP_DATA_W        = 32;
	localparam int          CDTP_TAG_W         = 3;
	localparam int          CDTP_BUF_DEPTH     = 2;
	localparam logic [2:0]  CDTP_TAG_OLDEST    = 3'h0;
	localparam logic [2:0]  CDTP_TAG_SECOND    = 3'h1;
	localparam logic [2:0]  CDTP_TAG_THIRD     = 3'h2;
	localparam logic [2:0]  CDTP_TAG_EIGHTH    = 3'h7;
	localparam logic [2:0]  CDTP_FROM_TAG_MAX  = 3'h1;
	localparam logic [31:0] CDTP_DATA_RST      = 32'h0000_0000;
endpackage

// file: logic/cdtp_skid_buf.sv
// Purpose: Two-entry valid/ready buffer for one data word plus tag
// Assumes: Single clock, synchronous active-high reset
// Notes:   Full ready stays low so a stalled sink loses nothing
`timescale 1ns/1ps
`default_nettype none
module cdtp_skid_buf
	import cdtp_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   srst_i,
	input  wire logic                   in_valid_i,
	output logic                        in_ready_o,
	input  wire logic [CDTP_DATA_W-1:0] in_data_i,
	input  wire logic [CDTP_TAG_W-1:0]  in_tag_i,
	output logic                        out_valid_o,
	input  wire logic                   out_ready_i,
	output logic      [CDTP_DATA_W-1:0] out_data_o,
	output logic      [CDTP_TAG_W-1:0]  out_tag_o
);
	logic [CDTP_DATA_W-1:0] mem_data [CDTP_BUF_DEPTH];
	logic [CDTP_TAG_W-1:0]  mem_tag  [CDTP_BUF_DEPTH];
	logic                   wr_ptr;
	logic                   rd_ptr;
	logic [1:0]             count;
	logic                   push;
	logic                   pop;

	assign in_ready_o  = (count != 2'h2);
	assign out_valid_o = (count != 2'h0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_data[rd_ptr];
	assign out_tag_o   = mem_tag[rd_ptr];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_data[wr_ptr] <= in_data_i;
			mem_tag[wr_ptr]  <= in_tag_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	chk_buf_no_overflow: assert property (
		@(posedge clk_i) disable iff (srst_i)
		count <= 2'h2)
		else $error("buffer count above depth");
endmodule
`default_nettype wire

// file: logic/cdtp_port.sv
// Purpose: Core-side data transfer port toward an attached coprocessor
// Assumes: Coprocessor shares clk_i; inputs synchronous to it
// Notes:   To-direction words are sent strictly in order
//
// Behaviour
// - To tags 010..111 select third..eighth oldest
// - Core drives to order tag fixed 000
// - Reorder-limit input is ignored entirely
// - To data meaningful only with strobe
// - From tag sampled only with strobe
// - From tag 000 oldest, 001 second, upward
// - To strobe marks each cycle with operand
// - To tag 000 oldest, 001 second oldest
`timescale 1ns/1ps
`default_nettype none
module cdtp_port
	import cdtp_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   srst_i,
	// Core operand side
	input  wire logic                   core_to_valid_i,
	output logic                        core_to_ready_o,
	input  wire logic [CDTP_DATA_W-1:0] core_to_data_i,
	// Coprocessor to-direction pins
	output logic                        to_data_strobe_o,
	output logic      [CDTP_TAG_W-1:0]  to_data_order_tag_o,
	output logic      [CDTP_DATA_W-1:0] to_coproc_data_word_o,
	input  wire logic [CDTP_TAG_W-1:0]  to_data_reorder_limit_i,
	input  wire logic                   to_coproc_ready_i,
	// Coprocessor from-direction pins
	input  wire logic                   from_data_strobe_i,
	input  wire logic [CDTP_TAG_W-1:0]  from_data_order_tag_i,
	input  wire logic [CDTP_DATA_W-1:0] from_coproc_data_word_i,
	// Core result side
	output logic                        core_from_valid_o,
	output logic      [CDTP_DATA_W-1:0] core_from_data_o,
	output logic      [CDTP_TAG_W-1:0]  core_from_tag_o,
	output logic                        core_from_tag_err_o
);
	typedef enum logic [1:0] {
		CDTP_ST_IDLE = 2'b01,
		CDTP_ST_SEND = 2'b10
	} cdtp_state_e;

	cdtp_state_e            state;
	cdtp_state_e            next_state;
	logic                   buf_valid;
	logic                   buf_ready;
	logic [CDTP_DATA_W-1:0] buf_data;
	logic [CDTP_TAG_W-1:0]  buf_tag;
	logic                   send_done;

	// Returns 1 when a from tag is one this core accepts
	function automatic logic cdtp_tag_ok(input logic [CDTP_TAG_W-1:0] t);
		cdtp_tag_ok = (t <= CDTP_FROM_TAG_MAX);
	endfunction

	// Limit pin is deliberately unused; tag never exceeds 000 anyway
	cdtp_skid_buf u_to_buf (
		.clk_i       (clk_i),
		.srst_i      (srst_i),
		.in_valid_i  (core_to_valid_i),
		.in_ready_o  (core_to_ready_o),
		.in_data_i   (core_to_data_i),
		.in_tag_i    (CDTP_TAG_OLDEST),
		.out_valid_o (buf_valid),
		.out_ready_i (buf_ready),
		.out_data_o  (buf_data),
		.out_tag_o   (buf_tag)
	);

	assign send_done = (state == CDTP_ST_SEND) && to_coproc_ready_i;
	assign buf_ready = (state == CDTP_ST_IDLE) || send_done;

	always_comb begin
		case (state)
			CDTP_ST_IDLE:
				next_state = buf_valid ? CDTP_ST_SEND : CDTP_ST_IDLE;
			CDTP_ST_SEND:
				if (to_coproc_ready_i && !buf_valid)
					next_state = CDTP_ST_IDLE;
				else
					next_state = CDTP_ST_SEND;
			default:
				next_state = CDTP_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i)
			state <= CDTP_ST_IDLE;
		else
			state <= next_state;
	end

	// Output stage holds word until coprocessor accepts it
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			to_data_strobe_o      <= 1'b0;
			to_data_order_tag_o   <= CDTP_TAG_OLDEST;
			to_coproc_data_word_o <= CDTP_DATA_RST;
		end else if (buf_valid && buf_ready) begin
			to_data_strobe_o      <= 1'b1;
			to_data_order_tag_o   <= buf_tag;
			to_coproc_data_word_o <= buf_data;
		end else if (send_done) begin
			to_data_strobe_o      <= 1'b0;
		end
	end

	// Tag and data captured only with strobe; others ignored
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			core_from_valid_o   <= 1'b0;
			core_from_data_o    <= CDTP_DATA_RST;
			core_from_tag_o     <= CDTP_TAG_OLDEST;
			core_from_tag_err_o <= 1'b0;
		end else begin
			core_from_valid_o   <= from_data_strobe_i;
			core_from_tag_err_o <= from_data_strobe_i &&
				!cdtp_tag_ok(from_data_order_tag_i);
			if (from_data_strobe_i) begin
				core_from_data_o <= from_coproc_data_word_i;
				core_from_tag_o  <= from_data_order_tag_i;
			end
		end
	end

	// To-direction checks
	chk_to_tag_zero: assert property (
		@(posedge clk_i) disable iff (srst_i)
		to_data_order_tag_o == CDTP_TAG_OLDEST)
		else $error("to order tag not oldest");

	chk_to_tag_range: assert property (
		@(posedge clk_i) disable iff (srst_i)
		to_data_strobe_o |-> to_data_order_tag_o < CDTP_TAG_THIRD)
		else $error("to tag beyond second oldest");

	chk_to_data_hold: assert property (
		@(posedge clk_i) disable iff (srst_i)
		to_data_strobe_o && !to_coproc_ready_i |=>
		to_data_strobe_o && $stable(to_coproc_data_word_o))
		else $error("to data changed while stalled");

	chk_to_strobe_src: assert property (
		@(posedge clk_i) disable iff (srst_i)
		$rose(to_data_strobe_o) |-> $past(buf_valid))
		else $error("to strobe without operand");

	chk_limit_ignored: assert property (
		@(posedge clk_i) disable iff (srst_i)
		!$stable(to_data_reorder_limit_i) |->
		to_data_order_tag_o == CDTP_TAG_OLDEST)
		else $error("limit affected tag");

	// Idle stage takes a waiting word at the very next edge
	chk_to_load_first: assert property (
		@(posedge clk_i) disable iff (srst_i)
		!to_data_strobe_o && buf_valid |=>
		to_data_strobe_o && to_coproc_data_word_o == $past(buf_data))
		else $error("waiting word not presented");

	// Back-to-back words leave without a gap cycle
	chk_to_next_word: assert property (
		@(posedge clk_i) disable iff (srst_i)
		to_data_strobe_o && to_coproc_ready_i && buf_valid |=>
		to_data_strobe_o && to_coproc_data_word_o == $past(buf_data))
		else $error("next word not presented");

	chk_to_strobe_drop: assert property (
		@(posedge clk_i) disable iff (srst_i)
		to_data_strobe_o && to_coproc_ready_i && !buf_valid |=>
		!to_data_strobe_o)
		else $error("to strobe without operand left");

	chk_to_state_match: assert property (
		@(posedge clk_i) disable iff (srst_i)
		$onehot(state) && to_data_strobe_o == (state == CDTP_ST_SEND))
		else $error("to strobe and state disagree");

	// From-direction checks
	chk_from_capture: assert property (
		@(posedge clk_i) disable iff (srst_i)
		from_data_strobe_i |=> core_from_valid_o &&
		core_from_data_o == $past(from_coproc_data_word_i))
		else $error("from word not captured");

	chk_from_tag_hold: assert property (
		@(posedge clk_i) disable iff (srst_i)
		!from_data_strobe_i |=> $stable(core_from_tag_o))
		else $error("from tag changed without strobe");

	chk_from_tag_err: assert property (
		@(posedge clk_i) disable iff (srst_i)
		from_data_strobe_i && from_data_order_tag_i > CDTP_TAG_SECOND
		|=> core_from_tag_err_o)
		else $error("bad from tag not flagged");

	chk_from_data_hold: assert property (
		@(posedge clk_i) disable iff (srst_i)
		!from_data_strobe_i |=> $stable(core_from_data_o))
		else $error("from word changed without strobe");

	chk_from_tag_take: assert property (
		@(posedge clk_i) disable iff (srst_i)
		from_data_strobe_i |=>
		core_from_tag_o == $past(from_data_order_tag_i))
		else $error("from tag not captured");

	chk_from_valid_pulse: assert property (
		@(posedge clk_i) disable iff (srst_i)
		!from_data_strobe_i |=>
		!core_from_valid_o && !core_from_tag_err_o)
		else $error("from valid without strobe");

	chk_from_err_clear: assert property (
		@(posedge clk_i) disable iff (srst_i)
		from_data_strobe_i &&
		from_data_order_tag_i <= CDTP_FROM_TAG_MAX |=>
		!core_from_tag_err_o)
		else $error("good from tag flagged");
endmodule
`default_nettype wire

// file: dv/cdtp_copro_model.sv
// Purpose: Coprocessor-side partner of the transfer port
// Assumes: Shares clk_i, synchronous reset
// Notes:   Returns each accepted word inverted; slow mode stalls
`timescale 1ns/1ps
`default_nettype none
module cdtp_copro_model
	import cdtp_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   srst_i,
	input  wire logic                   slow_i,
	input  wire logic                   bad_i,
	input  wire logic                   strobe_i,
	input  wire logic [CDTP_DATA_W-1:0] data_i,
	output logic                        ready_o,
	output logic                        fstrobe_o,
	output logic      [CDTP_TAG_W-1:0]  ftag_o,
	output logic      [CDTP_DATA_W-1:0] fdata_o
);
	logic [7:0] lf;
	logic       par;
	always_ff @(posedge clk_i) begin
		lf <= srst_i ? 8'h5A : {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		ready_o <= !srst_i && (!slow_i || lf[0]);
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			fstrobe_o <= 1'b0;
			fdata_o <= 32'hA5A5_A5A5;
			ftag_o <= 3'h6;
			par <= 1'b0;
		end else if (strobe_i && ready_o) begin
			fstrobe_o <= 1'b1;
			fdata_o <= ~data_i;
			ftag_o <= bad_i ? 3'h5 : {2'h0, par};
			par <= ~par;
		end else begin
			fstrobe_o <= 1'b0;
			// Idle lines wander so a stale value never passes
			fdata_o <= ~fdata_o;
			ftag_o <= ~ftag_o;
		end
	end
endmodule
`default_nettype wire

// file: dv/coproc_data_transfer_port_tb_top.sv
// Purpose: Self-checking bench for the transfer port
// Assumes: Partner model drives the coprocessor pins except the reorder limit, which the bench drives
// Notes:   Slow phase fills the buffer until it refuses
`timescale 1ns/1ps
`default_nettype none
module coproc_data_transfer_port_tb_top
	import cdtp_pkg::*;
;
	logic        clk_i, srst_i, cv, slow, bad, cr, ts, tr, fs, cfv, cfe, pv;
	logic        hung, ets;
	logic [31:0] cd, rnd, td, fd, cfd, pd;
	logic [2:0]  lim, tt, ft, cft, pt;
	logic [31:0] q[$];
	int          n_fail, n_tests, n_ref, i, occ;
	cdtp_port i_dut (.clk_i(clk_i), .srst_i(srst_i), .core_to_valid_i(cv),
		.core_to_ready_o(cr), .core_to_data_i(cd), .to_data_strobe_o(ts),
		.to_data_order_tag_o(tt), .to_coproc_data_word_o(td),
		.to_data_reorder_limit_i(lim), .to_coproc_ready_i(tr),
		.from_data_strobe_i(fs), .from_data_order_tag_i(ft),
		.from_coproc_data_word_i(fd), .core_from_valid_o(cfv),
		.core_from_data_o(cfd), .core_from_tag_o(cft),
		.core_from_tag_err_o(cfe));
	cdtp_copro_model i_cop (.clk_i(clk_i), .srst_i(srst_i), .slow_i(slow),
		.bad_i(bad), .strobe_i(ts), .data_i(td), .ready_o(tr),
		.fstrobe_o(fs), .ftag_o(ft), .fdata_o(fd));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Words held in the two-entry buffer, output stage excluded
	function automatic int buffered(input int n, input logic s);
		return n - int'(s);
	endfunction
	task automatic check(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic report_and_stop;
		if (n_fail == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic send(input logic [31:0] w);
		int k;
		cv <= 1'b1;
		cd <= w;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (!cr && k < 200);
		check("to ready", cr, 1'b1);
		if (cr) q.push_back(w);
		else hung = 1'b1;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (srst_i) begin
			pv = 1'b0;
			pd = CDTP_DATA_RST;
			pt = CDTP_TAG_OLDEST;
			occ = 0;
			ets = 1'b0;
		end else begin
			check("to tag", tt, CDTP_TAG_OLDEST);
			check("to strobe", ts, ets);
			check("to ready", cr, buffered(occ, ts) != 2);
			ets = (ts && !tr) || buffered(occ, ts) > 0;
			occ += int'(cv && cr) - int'(ts && tr);
			if (ts && tr) begin
				check("to spare", q.size() != 0, 1);
				if (q.size() != 0) check("to word", td, q.pop_front());
			end
			n_ref += cv && !cr;
			check("from valid", cfv, pv);
			check("from err", cfe, pv && pt > CDTP_FROM_TAG_MAX);
			check("from word", cfd, pd);
			check("from tag", cft, pt);
			if (fs) begin
				pd = fd;
				pt = ft;
			end
			pv = fs;
		end
	end
	initial begin
		srst_i = 1'b1;
		{cv, slow, bad, cd, lim} = '0;
		hung = 1'b0;
		{n_fail, n_tests, n_ref} = '0;
		rnd = 32'hE1791F26;
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		for (i = 0; i < 48 && !hung; i++) begin
			rnd = lfsr(rnd);
			slow <= i >= 16;
			bad <= i >= 40;
			lim <= rnd[2:0];
			send(i == 0 ? 32'hFFFF_FFFF : rnd);
		end
		cv <= 1'b0;
		for (i = 0; i < 400 && q.size() != 0; i++) @(posedge clk_i);
		repeat (3) @(posedge clk_i);
		check("drained", 32'(q.size()), 0);
		check("refused", n_ref != 0, 1);
		report_and_stop;
	end
endmodule
`default_nettype wire
